// >>> verilog/sdma_pkg.sv
package sdma_pkg;
   // Channel count and field widths
   localparam int          SDMA_NCH      = 6;
   localparam int          SDMA_AW       = 16;
   localparam int          SDMA_DW       = 16;
   localparam int          SDMA_ECW      = 16;
   localparam int          SDMA_FCW      = 8;
   localparam int          SDMA_SSW      = 4;
   localparam int          SDMA_NEV      = 16;
   // Address step modes of a 2-bit mode field
   localparam logic [1:0]  SDMA_IDX_CONST = 2'h0;
   localparam logic [1:0]  SDMA_IDX_INC   = 2'h1;
   localparam logic [1:0]  SDMA_IDX_DEC   = 2'h2;
   localparam logic [1:0]  SDMA_IDX_SEL   = 2'h3;
   // Channel mode word field positions
   localparam int          SDMA_MC_AUTO  = 15;
   localparam int          SDMA_MC_IRQEN = 14;
   localparam int          SDMA_MC_CHANNEL_IRQ_MODE  = 13;
   localparam int          SDMA_MC_ABU   = 12;
   localparam int          SDMA_MC_DWORD = 11;
   localparam int          SDMA_MC_SMODE = 5;
   localparam int          SDMA_MC_SOURCE_INDEX_SELECT  = 4;
   localparam int          SDMA_MC_DMODE = 1;
   localparam int          SDMA_MC_DEST_INDEX_SELECT  = 0;
   // Sync and frame count word field positions
   localparam int          SDMA_SF_SYNC  = 12;
   localparam int          SDMA_SF_FRM   = 0;
   localparam logic [3:0]  SDMA_SYNC_NONE = 4'h0;
   // Reset values and unit steps
   localparam logic [15:0] SDMA_WORD_RST = 16'h0000;
   localparam logic [7:0]  SDMA_FCNT_RST = 8'h00;
   localparam logic [15:0] SDMA_ONE      = 16'h0001;
   localparam logic [7:0]  SDMA_FONE     = 8'h01;

   typedef enum logic [1:0] {SDMA_IDLE, SDMA_READ, SDMA_WRITE} sdma_state_e;
   typedef logic [2:0] sdma_chid_t;
endpackage : sdma_pkg

// >>> verilog/sdma_arb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdma_arb_if;
   import sdma_pkg::*;
   logic [SDMA_NCH-1:0] req;
   logic [SDMA_NCH-1:0] hi;
   logic                take;
   logic                valid;
   sdma_chid_t          id;
   modport requester (output req, output hi, output take, input valid, input id);
   modport arbiter   (input req, input hi, input take, output valid, output id);
endinterface : sdma_arb_if
`default_nettype wire

// >>> verilog/sdma_arb.sv
`timescale 1ns/100ps
`default_nettype none
module sdma_arb (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Requests and grant
   sdma_arb_if.arbiter     arb
);
   import sdma_pkg::*;

   sdma_chid_t hi_last_r;
   sdma_chid_t lo_last_r;
   logic       hv, lv;
   sdma_chid_t hid, lid;

   // rotating search
   // Scan from the slot after the last winner; the nearest hit is written last
   always_comb begin
      hv  = 1'b0;
      lv  = 1'b0;
      hid = '0;
      lid = '0;
      for (int k = SDMA_NCH; k >= 1; k--) begin
         if (arb.req[(int'(hi_last_r) + k) % SDMA_NCH] && arb.hi[(int'(hi_last_r) + k) % SDMA_NCH]) begin
            hv  = 1'b1;
            hid = 3'((int'(hi_last_r) + k) % SDMA_NCH);
         end
         if (arb.req[(int'(lo_last_r) + k) % SDMA_NCH] && !arb.hi[(int'(lo_last_r) + k) % SDMA_NCH]) begin
            lv  = 1'b1;
            lid = 3'((int'(lo_last_r) + k) % SDMA_NCH);
         end
      end
   end

   // High level wins over low
   assign arb.valid = hv | lv;
   assign arb.id    = hv ? hid : lid;

   // Remember the winner of each level
   always_ff @(posedge clk) begin
      if (rst) begin
         hi_last_r <= 3'h5;
         lo_last_r <= 3'h5;
      end else if (arb.take && hv) begin
         hi_last_r <= hid;
      end else if (arb.take && lv) begin
         lo_last_r <= lid;
      end
   end

   chk_hi_first: assert property (@(posedge clk) disable iff (rst)
      (arb.valid && |(arb.req & arb.hi)) |-> arb.hi[arb.id])
      else $error("low level granted over a high request");

   // With a rival waiting, the last winner of a level must not win again
   chk_no_repeat: assert property (@(posedge clk) disable iff (rst)
      (arb.take && hv && $countones(arb.req & arb.hi) > 1) |-> (hid != hi_last_r))
      else $error("round robin granted the same high channel twice");

   chk_lo_rotate: assert property (@(posedge clk) disable iff (rst)
      (arb.take && !hv && $countones(arb.req & ~arb.hi) > 1) |-> (lid != lo_last_r))
      else $error("round robin granted the same low channel twice");
endmodule : sdma_arb
`default_nettype wire

// >>> verilog/sdma_step.sv
`timescale 1ns/100ps
`default_nettype none
module sdma_step (
   // Clock and reset, used by checks only
   input  wire logic        clk,
   input  wire logic        rst,
   // Current address and step control
   input  wire logic [15:0] addr,
   input  wire logic [1:0]  mode,
   input  wire logic        sel,
   input  wire logic        last,
   input  wire logic        dw_first,
   // Index values
   input  wire logic [15:0] eidx_a,
   input  wire logic [15:0] eidx_b,
   input  wire logic [15:0] fidx_a,
   input  wire logic [15:0] fidx_b,
   // Next address
   output logic [15:0]      nxt
);
   import sdma_pkg::*;

   wire [15:0] eidx = sel ? eidx_b : eidx_a;
   wire [15:0] fidx = sel ? fidx_b : fidx_a;
   // element index except on the last transfer
   // frame index on the last transfer, one-frame blocks too
   wire [15:0] idx_v = last ? fidx : eidx;

   // hold, increment, decrement or indexed step
   // In indexed mode the first half of a doubleword steps by one to reach the low word
   assign nxt = (mode == SDMA_IDX_CONST) ? addr :
                (mode == SDMA_IDX_INC)   ? 16'(addr + SDMA_ONE) :
                (mode == SDMA_IDX_DEC)   ? 16'(addr - SDMA_ONE) :
                dw_first                 ? 16'(addr + SDMA_ONE) :
                                           16'(addr + idx_v);

   chk_const_hold: assert property (@(posedge clk) disable iff (rst)
      (mode == SDMA_IDX_CONST) |-> (nxt == addr))
      else $error("constant mode moved the address");

   chk_frame_idx: assert property (@(posedge clk) disable iff (rst)
      (mode == SDMA_IDX_SEL && last && !dw_first) |-> (nxt == 16'(addr + fidx)))
      else $error("last transfer did not use the frame index");
endmodule : sdma_step
`default_nettype wire

// >>> verilog/sdma_top.sv
//Contract
// - Six channels, each with its own block-transfer context.
// - Controller wins over the processor for the internal memory.
// - Per-channel high or low priority; round robin within a level.
// - Source and destination addresses hold, increment, decrement or add an index.
// - Transfers of a channel may wait for a selected sync event.
// - A channel may interrupt at the half point of each frame or at full block.
// - Doubleword moves two 16-bit transfers, counted as one element.
// - Auto_reinit_enable reloads source, destination and count from global reloads.
// - Frame count is an 8-bit frames-per-block field.
// - Frame count zero, the reset value, means one frame.
// - Frame counter decrements on the final read of a frame.
// - Auto_reinit_enable reloads frame counter from the global frame reload.
// - Element count is 16 bits; all ones means 65536 elements.
// - Element counter decrements after each element read.
// - Auto_reinit_enable reloads element counter from the global count reload.
// - Mode fields pick which element and frame index registers apply.
// - Element index is added on all but the last transfer of a frame; a doubleword's first half steps by one.
// - Frame index is used on the last transfer of a frame.
// - Address map is fixed, unaffected by processor memory configuration bits.
// - Irq enable gates; irq mode picks half/full or frame/block events.
// - 4-bit sync select; zero means no synchronisation.
`timescale 1ns/100ps
`default_nettype none
module sdma_top (
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   // Channel setup
   input  wire logic [sdma_pkg::SDMA_NCH-1:0]         ch_start,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0]         ch_high_pri,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0][15:0]   channel_source_address,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0][15:0]   channel_dest_address,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0][15:0]   element_count_reg,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0][15:0]   sync_and_frame_count_reg,
   input  wire logic [sdma_pkg::SDMA_NCH-1:0][15:0]   channel_mode_reg,
   // Global reload and index values
   input  wire logic [15:0]                           global_source_reload,
   input  wire logic [15:0]                           global_dest_reload,
   input  wire logic [15:0]                           global_count_reload,
   input  wire logic [7:0]                            global_frame_reload,
   input  wire logic [15:0]                           element_index_a,
   input  wire logic [15:0]                           element_index_b,
   input  wire logic [15:0]                           frame_index_a,
   input  wire logic [15:0]                           frame_index_b,
   // Sync events, one pulse line per select code
   input  wire logic [sdma_pkg::SDMA_NEV-1:0]         sync_events,
   // Internal memory master
   output logic                                       mem_req,
   output logic                                       mem_we,
   output logic [15:0]                                mem_addr,
   output logic [15:0]                                mem_wdata,
   input  wire logic [15:0]                           mem_rdata,
   input  wire logic                                  mem_ack,
   // Processor access arbitration
   input  wire logic                                  cpu_req,
   output logic                                       cpu_grant,
   // Status and interrupts
   output logic [sdma_pkg::SDMA_NCH-1:0]              ch_active,
   output logic [sdma_pkg::SDMA_NCH-1:0]              ch_irq
);
   import sdma_pkg::*;

   logic [15:0]          src_r  [SDMA_NCH];
   logic [15:0]          dst_r  [SDMA_NCH];
   logic [15:0]          ecnt_r [SDMA_NCH];
   logic [15:0]          init_r [SDMA_NCH];
   logic [7:0]           fcnt_r [SDMA_NCH];
   logic [SDMA_NCH-1:0]  act_r;
   logic [SDMA_NCH-1:0]  pend_r;
   logic [SDMA_NCH-1:0]  irq_r;
   // Engine state
   sdma_state_e          st_r, st_nxt;
   sdma_chid_t           cur_r;
   logic                 half_r;
   logic                 elast_r;
   logic                 blk_r;
   logic                 fend_r;
   logic                 hhit_r;
   logic [15:0]          data_r;
   logic [SDMA_NCH-1:0]  elig;
   logic [15:0]          src_nxt, dst_nxt;

   sdma_arb_if arb_bus ();

   // Fields of the channel being served
   wire [15:0] mode_w   = channel_mode_reg[cur_r];
   wire        auto_w   = mode_w[SDMA_MC_AUTO];
   wire        irqen_w  = mode_w[SDMA_MC_IRQEN];
   wire        channel_irq_mode_w   = mode_w[SDMA_MC_CHANNEL_IRQ_MODE];
   wire        abu_w    = mode_w[SDMA_MC_ABU];
   wire        dword_w  = mode_w[SDMA_MC_DWORD];
   wire [15:0] ecnt_cur = ecnt_r[cur_r];
   wire [7:0]  fcnt_cur = fcnt_r[cur_r];

   // Transfer events
   wire rd_done = (st_r == SDMA_READ) && mem_ack;
   wire wr_done = (st_r == SDMA_WRITE) && mem_ack;
   // only the second half of a doubleword counts
   wire cnt_pt  = rd_done && (!dword_w || half_r);
   // count N means N+1 elements, so all ones gives 65536
   wire e_zero  = (ecnt_cur == SDMA_WORD_RST);
   // a frame count of zero leaves exactly one frame
   wire f_zero  = (fcnt_cur == SDMA_FCNT_RST);
   wire frm_end = cnt_pt && e_zero;
   wire blk_end = frm_end && f_zero;
   wire last_rd = e_zero && (!dword_w || half_r);
   wire last_wr = elast_r && (!dword_w || half_r);
   wire dw_more = dword_w && !half_r;

   // count down per element; auto_reinit_enable reload of the element count
   wire [15:0] ecnt_nxt = !blk_end ? (frm_end ? init_r[cur_r] : 16'(ecnt_cur - SDMA_ONE)) :
                          auto_w   ? global_count_reload : SDMA_WORD_RST;
   // one step per frame; auto_reinit_enable reload of the frame count
   wire [7:0]  fcnt_nxt = !blk_end ? 8'(fcnt_cur - SDMA_FONE) :
                          auto_w   ? global_frame_reload : SDMA_FCNT_RST;
   // Half-buffer point in buffer mode, checked after the element count moves
   wire        hhit     = cnt_pt && !frm_end && (ecnt_nxt == {1'b0, init_r[cur_r][15:1]});

   // a channel waits for its sync event unless sync is off
   genvar g;
   generate
      for (g = 0; g < SDMA_NCH; g++) begin : g_elig
         wire [3:0] ssel = sync_and_frame_count_reg[g][SDMA_SF_SYNC +: SDMA_SSW];
         assign elig[g] = act_r[g] && ((ssel == SDMA_SYNC_NONE) || pend_r[g]);
      end
   endgenerate

   // Arbiter hookup; requests only while the engine is idle
   assign arb_bus.req  = (st_r == SDMA_IDLE) ? elig : '0;
   assign arb_bus.hi   = ch_high_pri;
   assign arb_bus.take = (st_r == SDMA_IDLE) && arb_bus.valid;

   sdma_arb u_arb (
      .clk (clk),
      .rst (rst),
      .arb (arb_bus.arbiter)
   );

   // mode fields choose index set and step for each side
   sdma_step u_src_step (
      .clk      (clk),
      .rst      (rst),
      .addr     (src_r[cur_r]),
      .mode     (mode_w[SDMA_MC_SMODE +: 2]),
      .sel      (mode_w[SDMA_MC_SOURCE_INDEX_SELECT]),
      .last     (last_rd),
      .dw_first (dw_more),
      .eidx_a   (element_index_a),
      .eidx_b   (element_index_b),
      .fidx_a   (frame_index_a),
      .fidx_b   (frame_index_b),
      .nxt      (src_nxt)
   );

   sdma_step u_dst_step (
      .clk      (clk),
      .rst      (rst),
      .addr     (dst_r[cur_r]),
      .mode     (mode_w[SDMA_MC_DMODE +: 2]),
      .sel      (mode_w[SDMA_MC_DEST_INDEX_SELECT]),
      .last     (last_wr),
      .dw_first (dw_more),
      .eidx_a   (element_index_a),
      .eidx_b   (element_index_b),
      .fidx_a   (frame_index_a),
      .fidx_b   (frame_index_b),
      .nxt      (dst_nxt)
   );

   // Engine sequencing: read, write, and again for a doubleword's second half
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         SDMA_IDLE:  if (arb_bus.take) st_nxt = SDMA_READ;
         SDMA_READ:  if (mem_ack) st_nxt = SDMA_WRITE;
         // second half follows at once on the same channel
         SDMA_WRITE: if (mem_ack) st_nxt = dw_more ? SDMA_READ : SDMA_IDLE;
         default:    st_nxt = SDMA_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r   <= SDMA_IDLE;
         cur_r  <= '0;
         half_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (arb_bus.take) cur_r <= arb_bus.id;
         if (wr_done) half_r <= dw_more;
      end
   end

   // Read-side capture of data and end markers
   always_ff @(posedge clk) begin
      if (rst) begin
         data_r  <= SDMA_WORD_RST;
         elast_r <= 1'b0;
         blk_r   <= 1'b0;
         fend_r  <= 1'b0;
         hhit_r  <= 1'b0;
      end else if (rd_done) begin
         data_r  <= mem_rdata;
         elast_r <= e_zero;
         blk_r   <= blk_end;
         fend_r  <= frm_end;
         hhit_r  <= hhit;
      end
   end

   // Per-channel context; a start pulse overrides any update in the same cycle
   // globals are sampled only at the block end, so early rewrites are safe
   // unchanged globals simply repeat the same block
   always_ff @(posedge clk) begin
      for (int i = 0; i < SDMA_NCH; i++) begin
         if (rst) begin
            src_r[i]  <= SDMA_WORD_RST;
            dst_r[i]  <= SDMA_WORD_RST;
            ecnt_r[i] <= SDMA_WORD_RST;
            init_r[i] <= SDMA_WORD_RST;
            fcnt_r[i] <= SDMA_FCNT_RST;
         end else if (ch_start[i]) begin
            src_r[i]  <= channel_source_address[i];
            dst_r[i]  <= channel_dest_address[i];
            ecnt_r[i] <= element_count_reg[i];
            init_r[i] <= element_count_reg[i];
            fcnt_r[i] <= sync_and_frame_count_reg[i][SDMA_SF_FRM +: SDMA_FCW];
         end else if (cur_r == 3'(i)) begin
            if (rd_done) src_r[i] <= (blk_end && auto_w) ? global_source_reload : src_nxt;
            if (cnt_pt) ecnt_r[i] <= ecnt_nxt;
            if (frm_end) fcnt_r[i] <= fcnt_nxt;
            if (blk_end && auto_w) init_r[i] <= global_count_reload;
            // auto_reinit_enable reload of destination after the block's last write
            if (wr_done) dst_r[i] <= (blk_r && !dw_more && auto_w) ? global_dest_reload : dst_nxt;
         end
      end
   end

   // Activity, sync latches and interrupt pulses
   always_ff @(posedge clk) begin
      for (int i = 0; i < SDMA_NCH; i++) begin
         if (rst) begin
            act_r[i]  <= 1'b0;
            pend_r[i] <= 1'b0;
            irq_r[i]  <= 1'b0;
         end else begin
            // block done without auto_reinit_enable stops the channel
            if (ch_start[i]) act_r[i] <= 1'b1;
            else if (wr_done && !dw_more && cur_r == 3'(i) && blk_r && !auto_w) act_r[i] <= 1'b0;
            // event latch, a new event wins over the clear
            if (sync_events[sync_and_frame_count_reg[i][SDMA_SF_SYNC +: SDMA_SSW]]
                && sync_and_frame_count_reg[i][SDMA_SF_SYNC +: SDMA_SSW] != SDMA_SYNC_NONE)
               pend_r[i] <= 1'b1;
            else if (arb_bus.take && arb_bus.id == 3'(i)) pend_r[i] <= 1'b0;
            // enable gates, mode picks half/full or frame/block
            irq_r[i] <= wr_done && !dw_more && cur_r == 3'(i) && irqen_w
                        && (blk_r || (channel_irq_mode_w && (abu_w ? hhit_r : fend_r)));
         end
      end
   end

   // processor gets the memory only when the controller leaves it
   assign cpu_grant = cpu_req && !mem_req;
   assign mem_req   = (st_r != SDMA_IDLE);
   assign mem_we    = (st_r == SDMA_WRITE);
   // addresses go out unmapped, whatever the processor memory setup
   assign mem_addr  = (st_r == SDMA_WRITE) ? dst_r[cur_r] : src_r[cur_r];
   assign mem_wdata = data_r;
   assign ch_active = act_r;
   assign ch_irq    = irq_r;

   chk_cpu_yield: assert property (@(posedge clk) disable iff (rst)
      mem_req |-> !cpu_grant)
      else $error("processor granted during a controller access");

   chk_sync_wait: assert property (@(posedge clk) disable iff (rst)
      arb_bus.take |-> (pend_r[arb_bus.id]
         || sync_and_frame_count_reg[arb_bus.id][SDMA_SF_SYNC +: SDMA_SSW] == SDMA_SYNC_NONE))
      else $error("channel started without its sync event");

   chk_elem_dec: assert property (@(posedge clk) disable iff (rst)
      (cnt_pt && !e_zero && !ch_start[cur_r]) |=>
         ecnt_r[$past(cur_r)] == 16'($past(ecnt_cur) - SDMA_ONE))
      else $error("element count did not step down by one");

   chk_frame_dec: assert property (@(posedge clk) disable iff (rst)
      (cnt_pt && !ch_start[cur_r]) |=> fcnt_r[$past(cur_r)] ==
         ($past(frm_end) ? ($past(f_zero) ? $past(fcnt_nxt) : 8'($past(fcnt_cur) - SDMA_FONE))
                         : $past(fcnt_cur)))
      else $error("frame count moved off a frame's last read");

   chk_auto_load: assert property (@(posedge clk) disable iff (rst)
      (blk_end && auto_w && !ch_start[cur_r]) |=>
         ecnt_r[$past(cur_r)] == $past(global_count_reload)
         && fcnt_r[$past(cur_r)] == $past(global_frame_reload))
      else $error("auto_reinit_enable reload of the counters missed");

   chk_dword_pair: assert property (@(posedge clk) disable iff (rst)
      (wr_done && dw_more) |=> (st_r == SDMA_READ && half_r && $stable(cur_r)))
      else $error("doubleword second half not issued");

   chk_stop_done: assert property (@(posedge clk) disable iff (rst)
      (wr_done && !dw_more && blk_r && !auto_w && !ch_start[cur_r]) |=> !act_r[$past(cur_r)])
      else $error("channel kept running after its block");

   chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
      (|irq_r) |-> ($past(irqen_w) && $past(wr_done)))
      else $error("interrupt raised while disabled");
endmodule : sdma_top
`default_nettype wire

// >>> sim/sdma_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdma_mem_model (
   // Clock and stall control
   input  wire logic        clk,
   input  wire logic        slow,
   // Memory bus
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   output logic             mem_ack,
   output logic [15:0]      mem_rdata
);
   logic [1:0] wait_r = 2'h0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 16'h0000;
   // Answer on the falling edge; idle data toggles so a stale word never matches
   always @(negedge clk) begin
      if (mem_req && wait_r >= {slow, 1'b0}) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_we ? ~mem_rdata : mem_addr ^ 16'hc3c3; // Content is address-keyed
         wait_r    <= 2'h0;
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_r    <= mem_req ? wait_r + 2'h1 : 2'h0;
      end
   end
endmodule : sdma_mem_model
`default_nettype wire

// >>> sim/six_channel_dma_controller_test.sv
`timescale 1ns/100ps
`default_nettype none
module six_channel_dma_controller_test;
   import sdma_pkg::*;
   localparam logic [15:0] KEY = 16'hc3c3;
   // Stimulus
   logic                      clk = 1'b0, rst = 1'b1, slow = 1'b0, cpu_req = 1'b0;
   logic [SDMA_NCH-1:0]       ch_start = '0, ch_high_pri = '0;
   logic [SDMA_NCH-1:0][15:0] src = '0, dst = '0, cnt = '0, sfc = '0, mode = '0;
   logic [15:0]               gsa = '0, gda = '0, gcr = '0, ea = '0, eb = '0, fa = '0, fb = '0;
   logic [7:0]                gfr = '0;
   logic [SDMA_NEV-1:0]       sync_events = '0;
   // Design outputs
   logic                      mem_req, mem_we, mem_ack, cpu_grant;
   logic [15:0]               mem_addr, mem_wdata, mem_rdata;
   logic [SDMA_NCH-1:0]       ch_active, ch_irq;
   // Expected writes and counters
   logic [31:0]               exp_q[$];
   int                        n_mismatch = 0, checks_done = 0, n_wr = 0;
   int                        exp_irq[SDMA_NCH] = '{default: 0}, n_irq[SDMA_NCH] = '{default: 0};

   always #25 clk = ~clk;

   sdma_top u_dut (.clk, .rst, .ch_start, .ch_high_pri, .channel_source_address(src),
      .channel_dest_address(dst), .element_count_reg(cnt), .sync_and_frame_count_reg(sfc),
      .channel_mode_reg(mode), .global_source_reload(gsa), .global_dest_reload(gda),
      .global_count_reload(gcr), .global_frame_reload(gfr), .element_index_a(ea),
      .element_index_b(eb), .frame_index_a(fa), .frame_index_b(fb), .sync_events,
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .cpu_req,
      .cpu_grant, .ch_active, .ch_irq);
   sdma_mem_model u_mem (.clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_ack, .mem_rdata);

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                        input logic [15:0] ix);
      return m == SDMA_IDX_CONST ? a : m == SDMA_IDX_INC ? a + 16'h0001 :
             m == SDMA_IDX_DEC ? a - 16'h0001 : a + ix;
   endfunction : step

   // predict every write of one channel's block
   task automatic plan(input int ch, input logic [15:0] c, input logic [7:0] f,
                       input logic [15:0] m);
      logic [15:0] s, d;
      s = 16'($urandom);
      d = 16'($urandom);
      src[ch] = s;
      dst[ch] = d;
      cnt[ch] = c;
      sfc[ch] = {8'h00, f};
      mode[ch] = m;
      // Buffer mode adds one half-point pulse per frame once a frame holds two elements
      exp_irq[ch] += m[14] ? (m[13] ? (m[12] ? int'(c != 16'h0000) * (int'(f) + 1) + 1
                                             : int'(f) + 1) : 1) : 0;
      for (int j = 0; j <= int'(f); j++) begin
         for (int e = 0; e <= int'(c); e++) begin
            if (m[SDMA_MC_DWORD]) begin
               exp_q.push_back({d, s ^ KEY});
               s = step(s, m[6:5], 16'h0001);
               d = step(d, m[2:1], 16'h0001);
            end
            exp_q.push_back({d, s ^ KEY});
            s = step(s, m[6:5], e == int'(c) ? (m[4] ? fb : fa) : (m[4] ? eb : ea));
            d = step(d, m[2:1], e == int'(c) ? (m[0] ? fb : fa) : (m[0] ? eb : ea));
         end
      end
   endtask : plan

   task automatic go(input logic [5:0] m);
      ch_start = m;
      @(negedge clk);
      ch_start = 6'h00;
   endtask : go

   // Bounded wait for all channels to stop, then compare interrupt counts
   task automatic end_test(input string name);
      int n;
      n = 0;
      while ((ch_active !== 6'h00 || exp_q.size() != 0) && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check("drained", 32'h0, n / 2000);
      repeat (2) @(negedge clk);
      for (int i = 0; i < SDMA_NCH; i++) check("irq count", exp_irq[i], n_irq[i]);
      $display("test %s done", name);
   endtask : end_test

   // Pair each finished write with the oldest note; the processor must lose to transfers
   always @(posedge clk) begin
      if (mem_req === 1'b1 && mem_we === 1'b1 && mem_ack === 1'b1) begin
         n_wr++;
         check("write", exp_q.size() ? exp_q.pop_front() : 32'hxxxxxxxx, {mem_addr, mem_wdata});
      end
      for (int i = 0; i < SDMA_NCH; i++) n_irq[i] += int'(ch_irq[i] === 1'b1);
      if (mem_req === 1'b1) check("cpu_grant", 32'h0, cpu_grant);
      else check("cpu_grant", {31'h0, cpu_req}, cpu_grant);
   end

   // Processor contends at random
   always @(negedge clk) cpu_req <= 1'($urandom);

   initial begin
      logic [31:0] q[$];
      int          base;
      void'($urandom(32'h6340086d));
      repeat (3) @(negedge clk);
      rst = 1'b0;
      check("reset idle", 32'h0, {mem_req, ch_active, ch_irq});
      // two low channels alternate, channel 0 first
      plan(0, 16'h0001, 8'h00, 16'h0022);
      plan(1, 16'h0001, 8'h00, 16'h0022);
      q = exp_q;
      exp_q = {q[0], q[2], q[1], q[3]};
      go(6'h03);
      end_test("round robin");
      // high level is served before low
      ch_high_pri = 6'h10;
      plan(4, 16'h0001, 8'h00, 16'h0022);
      plan(3, 16'h0001, 8'h00, 16'h0022);
      go(6'h18);
      end_test("priority");
      // every step mode, indexed steps using the b index set
      for (int k = 0; k < 4; k++) begin
         {ea, eb, fa, fb} = {$urandom, $urandom};
         slow = k[0];
         ch_high_pri = 6'($urandom);
         plan(k, 16'($urandom % 3), 8'(k % 3), {2'b01, 1'($urandom), k[1], 1'($urandom),
              4'h0, 2'(k), k[0], 1'b0, 2'(3 - k), ~k[0]});
         go(6'h01 << k);
         end_test("step modes");
      end
      // reload from globals, then stop once reload is switched off
      {gsa, gda} = $urandom;
      gfr = 8'h01;
      plan(2, 16'h0000, 8'h00, 16'h8022);
      base = n_wr;
      go(6'h04);
      // globals rewritten after the block started must still be taken
      {gsa, gda} = $urandom;
      // the same globals serve both reloads
      for (int r = 0; r < 2; r++) begin
         exp_q.push_back({gda, gsa ^ KEY});
         exp_q.push_back({gda + 16'h0001, (gsa + 16'h0001) ^ KEY});
      end
      // Reload stays on until the second block is written out
      for (int n = 0; n < 400 && n_wr < base + 3; n++) @(negedge clk);
      mode[2][15] = 1'b0;
      end_test("auto_reinit_enable");
      // transfer waits for its selected event
      plan(5, 16'h0000, 8'h00, 16'h0022);
      sfc[5][15:12] = 4'h5;
      go(6'h20);
      repeat (10) @(negedge clk);
      check("sync hold", 32'h2, {ch_active[5], mem_req});
      sync_events[5] = 1'b1;
      @(negedge clk);
      sync_events[5] = 1'b0;
      end_test("sync");
      stop_test();
   end

   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("[ERR] watchdog expected done seen running");
      stop_test();
   end
endmodule : six_channel_dma_controller_test
`default_nettype wire
